// ==== rtl/dmairq_pkg.sv ====
// Package of register offsets, field positions and reset values for the DMA interrupt block.
package dmairq_pkg;
  localparam int unsigned        DMAIRQ_NCH        = 2;
  localparam logic [7:0]         OFS_TC_STATUS     = 8'h04;
  localparam logic [7:0]         OFS_TC_CLEAR      = 8'h08;
  localparam logic [7:0]         OFS_ERR_STATUS    = 8'h0C;
  localparam logic [7:0]         OFS_ERR_CLEAR     = 8'h10;
  localparam logic [7:0]         OFS_RAW_TC        = 8'h14;
  localparam logic [7:0]         OFS_RAW_ERR       = 8'h18;
  localparam logic [7:0]         OFS_TC_ENABLE     = 8'h1C;
  localparam logic [7:0]         OFS_ERR_ENABLE    = 8'h20;
  localparam logic [7:0]         OFS_IRQ_MASK      = 8'h24;
  localparam logic [7:0]         OFS_IRQ_STATUS    = 8'h28;
  localparam int unsigned        BIT_CH0           = 0;
  localparam int unsigned        BIT_CH1           = 1;
  localparam logic [1:0]         RST_PENDING       = 2'h0;
  localparam logic [1:0]         RST_ENABLE        = 2'h0;
  localparam logic [1:0]         RESP_OKAY         = 2'h0;
  localparam logic [1:0]         RESP_SLVERR       = 2'h2;
endpackage : dmairq_pkg

// ==== rtl/dmairq_latch.sv ====
// One channel's sticky pending bit with raw capture and write-one clear.
module dmairq_latch
  import dmairq_pkg::*;
(
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst_b,
  // Event, enable and clear.
  input  wire logic raw_evt,
  input  wire logic enable,
  input  wire logic clr,
  // State.
  output logic      raw_r,
  output logic      pending_r
);
  // Set wins over clear so an event in the clear cycle is kept.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      raw_r <= 1'b0;
    end else if (raw_evt) begin
      raw_r <= 1'b1;
    end else if (clr) begin
      raw_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pending_r <= 1'b0;
    end else if (raw_evt && enable) begin
      pending_r <= 1'b1;
    end else if (clr) begin
      pending_r <= 1'b0;
    end
  end
endmodule : dmairq_latch

// ==== rtl/dmairq_top.sv ====
// AXI4-Lite interrupt status and clear logic of a two-channel DMA controller.
// Function
// - Writing one to transfer-end clear bit 1 clears channel 1 transfer-end status.
// - Writing one to transfer-end clear bit 0 clears channel 0 transfer-end status.
// - A written zero to any clear bit leaves its status bit unchanged.
// - Error status bit 1 reads channel 1 pending error; register is read-only.
// - Error status bit 0 reads channel 0 pending error.
// - Error status shows the condition after the per-channel error enable.
// - Writing one to error clear bit 1 clears channel 1 error status.
// - Writing one to error clear bit 0 clears channel 0 error status.
// - A raw pre-enable error bit is kept per channel; it sets whatever the enable.
// - Transfer-end status sets on an enabled transfer end and stays until cleared.
module dmairq_top
  import dmairq_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Channel events, one-cycle pulses.
  input  wire logic [1:0]  tc_evt,
  input  wire logic [1:0]  err_evt,
  // AXI4-Lite write address.
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [7:0]  awaddr,
  // AXI4-Lite write data.
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  // AXI4-Lite write response.
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  // AXI4-Lite read.
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [7:0]  araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  // Interrupt.
  output logic             irq
);
  logic [1:0]  tc_en_r;
  logic [1:0]  err_en_r;
  logic [1:0]  mask_r;
  logic [1:0]  tc_raw;
  logic [1:0]  tc_pend;
  logic [1:0]  err_raw;
  logic [1:0]  err_pend;
  logic        aw_got_r;
  logic        w_got_r;
  logic [7:0]  aw_addr_r;
  logic [31:0] w_data_r;
  logic        w_lane0_r;
  logic        wr_go;
  logic [1:0]  tc_clr;
  logic [1:0]  err_clr;
  logic [1:0]  wbits;
  logic [1:0]  sum_stat;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a[7:2] == ofs[7:2]);
  endfunction : hit

  // Only byte lane 0 carries live bits; upper bits are dropped on write.
  assign wbits  = w_lane0_r ? w_data_r[1:0] : 2'h0;
  assign wr_go  = aw_got_r && w_got_r && !bvalid;
  // A zero in a clear bit yields no clear pulse.
  assign tc_clr[BIT_CH1]  = wr_go && hit(aw_addr_r, OFS_TC_CLEAR) && wbits[BIT_CH1];
  assign tc_clr[BIT_CH0]  = wr_go && hit(aw_addr_r, OFS_TC_CLEAR) && wbits[BIT_CH0];
  assign err_clr[BIT_CH1] = wr_go && hit(aw_addr_r, OFS_ERR_CLEAR) && wbits[BIT_CH1];
  assign err_clr[BIT_CH0] = wr_go && hit(aw_addr_r, OFS_ERR_CLEAR) && wbits[BIT_CH0];
  assign sum_stat = tc_pend | err_pend;

  genvar g;
  for (g = 0; g < 2; g++) begin : g_ch
    dmairq_latch u_tc (
      .clk       (clk),
      .rst_b     (rst_b),
      .raw_evt   (tc_evt[g]),
      .enable    (tc_en_r[g]),
      .clr       (tc_clr[g]),
      .raw_r     (tc_raw[g]),
      .pending_r (tc_pend[g])
    );
    dmairq_latch u_err (
      .clk       (clk),
      .rst_b     (rst_b),
      .raw_evt   (err_evt[g]),
      .enable    (err_en_r[g]),
      .clr       (err_clr[g]),
      .raw_r     (err_raw[g]),
      .pending_r (err_pend[g])
    );
  end

  // Address and data are taken in either order and held until both arrive.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_got_r  <= 1'b0;
      aw_addr_r <= 8'h00;
    end else if (awvalid && awready) begin
      aw_got_r  <= 1'b1;
      aw_addr_r <= awaddr;
    end else if (wr_go) begin
      aw_got_r  <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      w_got_r   <= 1'b0;
      w_data_r  <= 32'h0000_0000;
      w_lane0_r <= 1'b0;
    end else if (wvalid && wready) begin
      w_got_r   <= 1'b1;
      w_data_r  <= wdata;
      w_lane0_r <= wstrb[0];
    end else if (wr_go) begin
      w_got_r   <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      awready <= 1'b0;
      wready  <= 1'b0;
    end else begin
      awready <= !aw_got_r && !(awvalid && awready) && !bvalid;
      wready  <= !w_got_r && !(wvalid && wready) && !bvalid;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid <= 1'b1;
      case (1'b1)
        hit(aw_addr_r, OFS_TC_CLEAR), hit(aw_addr_r, OFS_ERR_CLEAR),
        hit(aw_addr_r, OFS_TC_ENABLE), hit(aw_addr_r, OFS_ERR_ENABLE),
        hit(aw_addr_r, OFS_IRQ_MASK), hit(aw_addr_r, OFS_IRQ_STATUS): begin
          bresp <= RESP_OKAY;
        end
        default: begin
          bresp <= RESP_SLVERR;
        end
      endcase
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Software-written enables and mask steer the latches and the interrupt.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tc_en_r  <= RST_ENABLE;
      err_en_r <= RST_ENABLE;
      mask_r   <= RST_ENABLE;
    end else if (wr_go) begin
      if (hit(aw_addr_r, OFS_TC_ENABLE)) begin
        tc_en_r <= wbits;
      end
      if (hit(aw_addr_r, OFS_ERR_ENABLE)) begin
        err_en_r <= wbits;
      end
      if (hit(aw_addr_r, OFS_IRQ_MASK)) begin
        mask_r <= wbits;
      end
    end
  end

  // The interrupt is registered so that it never glitches while status bits move.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= |(sum_stat & mask_r);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= RESP_OKAY;
    end else if (rvalid) begin
      arready <= 1'b0;
      if (rready) begin
        rvalid <= 1'b0;
      end
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rresp   <= RESP_OKAY;
      rdata   <= 32'h0000_0000;
      case (1'b1)
        hit(araddr, OFS_TC_STATUS):  rdata[1:0] <= tc_pend;
        hit(araddr, OFS_ERR_STATUS): rdata[1:0] <= err_pend;
        hit(araddr, OFS_RAW_TC):     rdata[1:0] <= tc_raw;
        hit(araddr, OFS_RAW_ERR):    rdata[1:0] <= err_raw;
        hit(araddr, OFS_TC_ENABLE):  rdata[1:0] <= tc_en_r;
        hit(araddr, OFS_ERR_ENABLE): rdata[1:0] <= err_en_r;
        hit(araddr, OFS_IRQ_MASK):   rdata[1:0] <= mask_r;
        hit(araddr, OFS_IRQ_STATUS): rdata[1:0] <= sum_stat;
        hit(araddr, OFS_TC_CLEAR), hit(araddr, OFS_ERR_CLEAR): rdata <= 32'h0000_0000;
        default: begin
          rresp <= RESP_SLVERR;
        end
      endcase
    end else begin
      arready <= 1'b1;
    end
  end

  // Assertions.
  property p_tc_clr1;
    @(posedge clk) disable iff (!rst_b)
      tc_clr[1] && !tc_evt[1] |=> !tc_pend[1];
  endproperty
  a_tc_clr1: assert property (p_tc_clr1) else $error("ch1 tc not cleared");

  property p_tc_clr0;
    @(posedge clk) disable iff (!rst_b)
      tc_clr[0] && !tc_evt[0] |=> !tc_pend[0];
  endproperty
  a_tc_clr0: assert property (p_tc_clr0) else $error("ch0 tc not cleared");

  property p_zero_keeps;
    @(posedge clk) disable iff (!rst_b)
      wr_go && hit(aw_addr_r, OFS_TC_CLEAR) && !wbits[0] |=>
        tc_pend[0] == $past(tc_pend[0]) || tc_pend[0];
  endproperty
  a_zero_keeps: assert property (p_zero_keeps) else $error("zero write cleared tc");

  property p_err_set1;
    @(posedge clk) disable iff (!rst_b)
      err_evt[1] && err_en_r[1] |=> err_pend[1];
  endproperty
  a_err_set1: assert property (p_err_set1) else $error("ch1 err not pending");

  property p_err_set0;
    @(posedge clk) disable iff (!rst_b)
      err_evt[0] && err_en_r[0] |=> err_pend[0];
  endproperty
  a_err_set0: assert property (p_err_set0) else $error("ch0 err not pending");

  property p_gate;
    @(posedge clk) disable iff (!rst_b)
      err_evt[0] && !err_en_r[0] && !err_pend[0] |=> !err_pend[0] && err_raw[0];
  endproperty
  a_gate: assert property (p_gate) else $error("disabled error reached status");

  property p_err_clr1;
    @(posedge clk) disable iff (!rst_b)
      err_clr[1] && !err_evt[1] |=> !err_pend[1];
  endproperty
  a_err_clr1: assert property (p_err_clr1) else $error("ch1 err not cleared");

  property p_err_clr0;
    @(posedge clk) disable iff (!rst_b)
      err_clr[0] && !err_evt[0] |=> !err_pend[0];
  endproperty
  a_err_clr0: assert property (p_err_clr0) else $error("ch0 err not cleared");

  property p_tc_sticky;
    @(posedge clk) disable iff (!rst_b)
      tc_pend[1] && !tc_clr[1] |=> tc_pend[1] [*1];
  endproperty
  a_tc_sticky: assert property (p_tc_sticky) else $error("tc status dropped");

  property p_irq;
    @(posedge clk) disable iff (!rst_b)
      |(sum_stat & mask_r) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq not raised");

  property p_irq_low;
    @(posedge clk) disable iff (!rst_b)
      !(|(sum_stat & mask_r)) |=> !irq;
  endproperty
  a_irq_low: assert property (p_irq_low) else $error("irq raised without cause");

  property p_tc_set1;
    @(posedge clk) disable iff (!rst_b)
      tc_evt[1] && tc_en_r[1] |=> tc_pend[1];
  endproperty
  a_tc_set1: assert property (p_tc_set1) else $error("ch1 tc not pending");

  property p_tc_set0;
    @(posedge clk) disable iff (!rst_b)
      tc_evt[0] && tc_en_r[0] |=> tc_pend[0];
  endproperty
  a_tc_set0: assert property (p_tc_set0) else $error("ch0 tc not pending");

  property p_raw_err1;
    @(posedge clk) disable iff (!rst_b)
      err_evt[1] |=> err_raw[1];
  endproperty
  a_raw_err1: assert property (p_raw_err1) else $error("ch1 raw error not set");

  property p_raw_err0;
    @(posedge clk) disable iff (!rst_b)
      err_evt[0] |=> err_raw[0];
  endproperty
  a_raw_err0: assert property (p_raw_err0) else $error("ch0 raw error not set");

  property p_pend_raw;
    @(posedge clk) disable iff (!rst_b)
      (err_pend & ~err_raw) == 2'h0;
  endproperty
  a_pend_raw: assert property (p_pend_raw) else $error("error pending without raw");

  property p_gate1;
    @(posedge clk) disable iff (!rst_b)
      err_evt[1] && !err_en_r[1] && !err_pend[1] |=> !err_pend[1] && err_raw[1];
  endproperty
  a_gate1: assert property (p_gate1) else $error("disabled ch1 error reached status");

  property p_err_sticky;
    @(posedge clk) disable iff (!rst_b)
      err_pend[0] && !err_clr[0] |=> err_pend[0];
  endproperty
  a_err_sticky: assert property (p_err_sticky) else $error("err status dropped");

  property p_zk_err;
    @(posedge clk) disable iff (!rst_b)
      wr_go && hit(aw_addr_r, OFS_ERR_CLEAR) && !wbits[1] && err_pend[1] |=> err_pend[1];
  endproperty
  a_zk_err: assert property (p_zk_err) else $error("zero write cleared err");

  property p_ro_status;
    @(posedge clk) disable iff (!rst_b)
      wr_go && hit(aw_addr_r, OFS_ERR_STATUS) |=> bvalid && bresp == RESP_SLVERR;
  endproperty
  a_ro_status: assert property (p_ro_status) else $error("status write accepted");

  property p_err_rd;
    @(posedge clk) disable iff (!rst_b)
      arvalid && arready && hit(araddr, OFS_ERR_STATUS) |=> rdata == {30'h0, $past(err_pend)};
  endproperty
  a_err_rd: assert property (p_err_rd) else $error("err status read wrong");
endmodule : dmairq_top

// ==== bench/dmairq_top_bench.sv ====
// Self-checking bench for the DMA interrupt status and clear block.
module dmairq_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import dmairq_pkg::*;

  logic        clk, rst_b, awvalid, wvalid, bready, arvalid, rready;
  logic [1:0]  tc_evt, err_evt, bresp, rresp, rs, m_tc, m_err, m_raw, tc_en, err_en, mask, d, e;
  logic [1:0]  m_rtc;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rdat;
  logic [3:0]  wstrb;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  int          fails = 0;
  int          num_checks = 0;
  int          cyc = 0;
  int          k;

  dmairq_top dut (.clk(clk), .rst_b(rst_b), .tc_evt(tc_evt), .err_evt(err_evt),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .irq(irq));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic wrap_up;
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up

  // The limit is far above the few thousand cycles the sequence needs.
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      fails++;
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] dw, output logic [1:0] r);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= dw;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk);
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    // Ready stays high: dropping it here would meet the next call's raise in one step.
    r = bresp;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] dr, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    dr = rdata;
    r = rresp;
  endtask : axi_rd

  // Model follows each accepted write; upper data bits are always zero.
  task automatic wr(input logic [7:0] a, input logic [1:0] dw, input logic [1:0] er);
    axi_wr(a, {30'h0, dw}, rs);
    chk({30'h0, rs}, {30'h0, er});
    if (a == OFS_TC_CLEAR) begin
      m_tc &= ~dw;
      m_rtc &= ~dw;
    end
    if (a == OFS_ERR_CLEAR) begin
      m_err &= ~dw;
      m_raw &= ~dw;
    end
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [1:0] exp);
    axi_rd(a, rdat, rs);
    chk(rdat, {30'h0, exp});
    chk({30'h0, rs}, {30'h0, RESP_OKAY});
  endtask : rd_chk

  task automatic ev(input logic [1:0] t, input logic [1:0] x);
    tc_evt <= t;
    err_evt <= x;
    @(posedge clk);
    tc_evt <= 2'h0;
    err_evt <= 2'h0;
    m_raw |= x;
    m_rtc |= t;
    m_tc |= t & tc_en;
    m_err |= x & err_en;
    @(posedge clk);
  endtask : ev

  task automatic verify;
    rd_chk(OFS_TC_STATUS, m_tc);
    rd_chk(OFS_ERR_STATUS, m_err);
    rd_chk(OFS_RAW_ERR, m_raw);
    rd_chk(OFS_RAW_TC, m_rtc);
    rd_chk(OFS_IRQ_STATUS, m_tc | m_err);
    chk({31'h0, irq}, {31'h0, |((m_tc | m_err) & mask)});
  endtask : verify

  initial begin
    {rst_b, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {tc_evt, err_evt, awaddr, araddr, wdata, wstrb} = 56'h0;
    {m_tc, m_err, m_raw, m_rtc, tc_en, err_en, mask} = 14'h0000;
    void'($urandom(28));
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    verify();
    // Each phase starts clean so that an enable change never meets an old pending bit.
    for (int p = 0; p < 4; p++) begin
      wr(OFS_TC_CLEAR, 2'h3, RESP_OKAY);
      wr(OFS_ERR_CLEAR, 2'h3, RESP_OKAY);
      tc_en = 2'($urandom);
      err_en = 2'(p);
      mask = 2'($urandom);
      wr(OFS_TC_ENABLE, tc_en, RESP_OKAY);
      wr(OFS_ERR_ENABLE, err_en, RESP_OKAY);
      wr(OFS_IRQ_MASK, mask, RESP_OKAY);
      repeat (30) begin
        k = $urandom % 3;
        d = 2'($urandom);
        e = 2'($urandom);
        case (k)
          0: ev(d, e);
          1: wr(OFS_TC_CLEAR, d, RESP_OKAY);
          default: wr(OFS_ERR_CLEAR, d, RESP_OKAY);
        endcase
        verify();
      end
    end
    ev(2'h3, 2'h3);
    wr(OFS_ERR_STATUS, 2'h3, RESP_SLVERR);
    verify();
    wr(8'h30, 2'h3, RESP_SLVERR);
    axi_rd(8'h30, rdat, rs);
    chk({30'h0, rs}, {30'h0, RESP_SLVERR});
    rd_chk(OFS_TC_CLEAR, 2'h0);
    rd_chk(OFS_ERR_CLEAR, 2'h0);
    rd_chk(OFS_TC_ENABLE, tc_en);
    rd_chk(OFS_ERR_ENABLE, err_en);
    rd_chk(OFS_IRQ_MASK, mask);
    wr(OFS_IRQ_STATUS, 2'h3, RESP_OKAY);
    verify();
    wrap_up();
  end
endmodule : dmairq_top_bench
